// *** logic/sdb_device.sv ***
// Summary of operation
// - download only when boot select low at release
// - clock pin level at release picks mode
// - sync mode uses clock, in, out, handshake
// - async mode uses in and out, handshake as run monitor
// - host sources serial clock in sync mode
// - handshake low when ready, high once receiving
// - bytes of eight bits, lsb first
// - sync bits sampled on serial clock rise
// - in sync mode, host waits for handshake low before sending
// - host drives clock pin high after reset in sync mode, low in async mode
// - after init, wait for reception, handshake low
// - byte processed, handshake low, wait again
// - only program bytes written to ram, not command or header
// - checksum match starts program at entry address
// - checksum mismatch clears ram, waits again
// - async mode handshake is program run monitor
// - frame is FAh, size low, high, checksum, data
// - checksum is low byte of data sum
// - store from 600h, run from 608h
// - async characters 8N1, lsb first
module sdb_device #(
    parameter int BIT_CYCLES = sdb_pkg::BIT_CYC  // async bit time in cycles
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    sdb_link_if.device       link,
    input  wire logic [15:0] rd_addr,
    output logic [7:0]       rd_data,
    output logic             run,
    output logic [15:0]      run_addr,
    output logic             sync_mode,
    output logic             enabled
);
    // ------------------------------------------------------------
    // link clock side: serial shifter
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sh;       // incoming bits
        logic [2:0] bitn;     // bit index within byte
        logic [7:0] hold;     // last complete byte
        logic       start_t;  // toggles on each first bit
        logic       done_t;   // toggles on each last bit
    } sdb_lnk_t;

    sdb_lnk_t l;       // link side state
    sdb_lnk_t next_l;  // link side next

    // shift in, lsb first, one bit per rising edge
    always_comb begin
        next_l      = l;
        next_l.sh   = {link.serial_in_pin, l.sh[7:1]};
        next_l.bitn = l.bitn + 1'b1;
        if (l.bitn == 3'h0) begin
            next_l.start_t = !l.start_t;
        end
        if (l.bitn == 3'h7) begin
            next_l.hold   = {link.serial_in_pin, l.sh[7:1]};
            next_l.done_t = !l.done_t;
        end
    end

    // clocked by the host-made serial clock
    always_ff @(posedge link.serial_clock_pin or negedge resetn) begin
        if (!resetn) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // ------------------------------------------------------------
    // system side state
    // ------------------------------------------------------------
    // sync vector bits: 0 boot, 1 clock pin, 2 serial in, 3 start, 4 done
    typedef struct packed {
        logic [4:0]                s1;      // first stage
        logic [4:0]                s2;      // second stage
        logic [4:0]                s3;      // third stage
        logic [4:0]                acc;     // accepted levels
        logic [1:0]                tg;      // last seen toggles
        sdb_pkg::sdb_dst_t         st;      // loader state
        logic                      smode;   // sync mode latched
        logic                      en;      // download enabled
        logic [sdb_pkg::CNT_W-1:0] cnt;     // init / byte index / clear
        logic [15:0]               size;    // program size
        logic [7:0]                csum;    // transmitted checksum
        logic [7:0]                sum;     // running sum
        logic                      busy;    // sync busy level
        logic                      u_act;   // async receive active
        logic [3:0]                u_bit;   // async bit index
        logic [15:0]               u_cnt;   // async bit timer
        logic [7:0]                u_sh;    // async shifter
        logic                      hs;      // handshake pin
        logic                      run;     // program executing
        logic [15:0]               raddr;   // entry address
        logic [7:0]                rdat;    // user read data
    } sdb_dev_t;

    sdb_dev_t r;       // registered state
    sdb_dev_t next_r;  // next state

    logic [7:0] ram [sdb_pkg::RAM_DEPTH];  // download ram
    logic       ram_we;                    // write strobe
    logic [sdb_pkg::RAM_AW-1:0] ram_wa;    // write index
    logic [7:0] ram_wd;                    // write data
    logic       bev;                       // byte event
    logic [7:0] bval;                      // byte value
    logic [15:0] roff;                     // user read offset

    // ------------------------------------------------------------
    // loader next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        ram_we = 1'b0;
        ram_wa = '0;
        ram_wd = '0;
        bev    = 1'b0;
        bval   = '0;
        roff   = rd_addr - sdb_pkg::LOAD_BASE;
        // three-stage synchronisers, accept when stages two and three agree
        next_r.s1  = {l.done_t, l.start_t, link.serial_in_pin,
                      link.serial_clock_pin, link.boot_select_pin};
        next_r.s2  = r.s1;
        next_r.s3  = r.s2;
        next_r.acc = (r.s2 & r.s3) | (r.acc & (r.s2 | r.s3));
        next_r.tg  = r.acc[4:3];
        next_r.cnt = r.cnt + 1'b1;

        // sync mode byte: busy on first bit, byte on last
        if (r.smode && r.acc[3] != r.tg[0]) begin
            next_r.busy = 1'b1;
        end
        if (r.smode && r.acc[4] != r.tg[1]) begin
            bev  = 1'b1;
            bval = l.hold;
        end

        // async receiver on the synchronised data line
        next_r.u_cnt = r.u_cnt + 1'b1;
        if (!r.smode && r.en) begin
            if (!r.u_act) begin
                next_r.u_cnt = '0;
                next_r.u_bit = '0;
                next_r.u_act = !r.acc[2];
            end else if (r.u_bit == 4'h0 && r.u_cnt == 16'(BIT_CYCLES / 2)) begin
                next_r.u_cnt = '0;
                next_r.u_bit = 4'h1;
                next_r.u_act = !r.acc[2];  // glitch, not a start bit
            end else if (r.u_bit != 4'h0 && r.u_cnt == 16'(BIT_CYCLES - 1)) begin
                next_r.u_cnt = '0;
                next_r.u_bit = r.u_bit + 1'b1;
                if (r.u_bit == 4'h9) begin
                    next_r.u_act = 1'b0;
                    bev  = r.acc[2];       // stop bit must be high
                    bval = r.u_sh;
                end else begin
                    next_r.u_sh = {r.acc[2], r.u_sh[7:1]};
                end
            end
        end

        unique case (r.st)
            sdb_pkg::D_STRAP: begin
                // straps caught once synchronisers have filled
                if (r.cnt == sdb_pkg::CNT_W'(sdb_pkg::STRAP_CYC - 1)) begin
                    next_r.en    = !r.acc[0];
                    next_r.smode = r.acc[1];
                    next_r.cnt   = '0;
                    next_r.st    = r.acc[0] ? sdb_pkg::D_OFF : sdb_pkg::D_INIT;
                end
            end
            sdb_pkg::D_OFF: begin
                next_r.cnt = r.cnt;
            end
            sdb_pkg::D_INIT: begin
                // handshake stays high until init ends
                if (r.cnt == sdb_pkg::CNT_W'(sdb_pkg::INIT_CYC - 1)) begin
                    next_r.busy = 1'b0;
                    next_r.st   = sdb_pkg::D_CMD;
                end
            end
            sdb_pkg::D_CMD: begin
                // anything but the command byte is dropped
                if (bev && bval == sdb_pkg::CMD_DOWNLOAD) begin
                    next_r.st = sdb_pkg::D_SZLO;
                end
            end
            sdb_pkg::D_SZLO: begin
                if (bev) begin
                    next_r.size[7:0] = bval;
                    next_r.st        = sdb_pkg::D_SZHI;
                end
            end
            sdb_pkg::D_SZHI: begin
                if (bev) begin
                    next_r.size[15:8] = bval;
                    next_r.st         = sdb_pkg::D_SUM;
                end
            end
            sdb_pkg::D_SUM: begin
                if (bev) begin
                    next_r.csum = bval;
                    next_r.sum  = '0;
                    next_r.cnt  = '0;
                    next_r.st   = (r.size == 16'h0000) ? sdb_pkg::D_RUN : sdb_pkg::D_DATA;
                    if (r.size == 16'h0000 && bval != 8'h00) begin
                        next_r.st = sdb_pkg::D_CLEAR;
                    end
                end
            end
            sdb_pkg::D_DATA: begin
                next_r.cnt = r.cnt;
                if (bev) begin
                    // store from the load base, bytes past the ram are not kept
                    ram_we     = (r.cnt < sdb_pkg::CNT_W'(sdb_pkg::RAM_DEPTH));
                    ram_wa     = r.cnt[sdb_pkg::RAM_AW-1:0];
                    ram_wd     = bval;
                    next_r.sum = r.sum + bval;
                    next_r.cnt = r.cnt + 1'b1;
                    if (r.cnt + 1'b1 == r.size) begin
                        next_r.cnt = '0;
                        // compare low byte of the sum with the sent one
                        next_r.st  = (r.sum + bval == r.csum) ? sdb_pkg::D_RUN : sdb_pkg::D_CLEAR;
                    end
                end
            end
            sdb_pkg::D_CLEAR: begin
                // wipe the ram, stay busy meanwhile
                ram_we = 1'b1;
                ram_wa = r.cnt[sdb_pkg::RAM_AW-1:0];
                if (r.cnt == sdb_pkg::CNT_W'(sdb_pkg::RAM_DEPTH - 1)) begin
                    next_r.busy = 1'b0;
                    next_r.st   = sdb_pkg::D_CMD;
                end
            end
            sdb_pkg::D_RUN: begin
                next_r.cnt   = r.cnt;
                next_r.run   = 1'b1;
                next_r.raddr = sdb_pkg::EXEC_START;
            end
        endcase

        // byte handled: drop busy unless still clearing or running
        if (bev && next_r.st != sdb_pkg::D_CLEAR && next_r.st != sdb_pkg::D_RUN) begin
            next_r.busy = 1'b0;
        end
        // a new first bit in the same cycle wins over the drop
        if (r.smode && r.acc[3] != r.tg[0]) begin
            next_r.busy = 1'b1;
        end

        // handshake: busy in sync mode, run monitor in async mode
        next_r.hs = r.smode ? next_r.busy : next_r.run;
        if (next_r.st == sdb_pkg::D_STRAP || next_r.st == sdb_pkg::D_INIT || next_r.st == sdb_pkg::D_OFF) begin
            next_r.hs = 1'b1;
        end
        next_r.rdat = (roff < 16'(sdb_pkg::RAM_DEPTH)) ? ram[roff[sdb_pkg::RAM_AW-1:0]] : 8'h00;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r      <= '0;
            r.s1   <= sdb_pkg::SYNC_RST;
            r.s2   <= sdb_pkg::SYNC_RST;
            r.s3   <= sdb_pkg::SYNC_RST;
            r.acc  <= sdb_pkg::SYNC_RST;
            r.st   <= sdb_pkg::D_STRAP;
            r.busy <= 1'b1;
            r.hs   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ram write port, no reset on storage
    always_ff @(posedge clock) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.serial_out_pin      = 1'b1;  // idle, nothing is sent back
    assign link.ready_handshake_pin = r.hs;
    assign rd_data                  = r.rdat;
    assign run                      = r.run;
    assign run_addr                 = r.raddr;
    assign sync_mode                = r.smode;
    assign enabled                  = r.en;
endmodule

// *** logic/sdb_pkg.sv ***
package sdb_pkg;
    // ------------------------------------------------------------
    // frame and memory layout
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_DOWNLOAD = 8'hFA;     // download command code
    localparam logic [15:0] LOAD_BASE    = 16'h0600;  // first stored program byte
    localparam logic [15:0] EXEC_START   = 16'h0608;  // entry after version field
    localparam int          RAM_DEPTH    = 2048;      // bytes of download ram
    localparam int          RAM_AW       = 11;        // ram index width

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ      = 250_000_000;       // system clock rate
    localparam int CLK_PERIOD_NS = 4;                 // system clock period
    localparam int BAUD_BPS      = 9600;              // async bit rate
    localparam int BIT_CYC       = CLOCK_HZ / BAUD_BPS;
    localparam int SCK_PERIOD_NS = 160;               // host serial clock period
    localparam int SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int STRAP_CYC     = 8;                 // wait before strap capture
    localparam int INIT_CYC      = 16;                // internal init length
    localparam int GUARD_CYC     = 16;                // host pause after a byte
    localparam int CNT_W         = 16;                // generic counter width
    localparam logic [4:0] SYNC_RST = 5'h07;          // synchroniser reset levels

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        D_STRAP = 10'h001, D_OFF  = 10'h002, D_INIT = 10'h004, D_CMD  = 10'h008,
        D_SZLO  = 10'h010, D_SZHI = 10'h020, D_SUM  = 10'h040, D_DATA = 10'h080,
        D_CLEAR = 10'h100, D_RUN  = 10'h200
    } sdb_dst_t;

    typedef enum logic [4:0] {
        H_WAIT = 5'h01, H_LOW = 5'h02, H_HIGH = 5'h04, H_GUARD = 5'h08, H_UART = 5'h10
    } sdb_hst_t;
endpackage

// *** logic/sdb_link_if.sv ***
interface sdb_link_if;
    logic boot_select_pin;      // low at reset release enables download
    logic serial_clock_pin;     // strap level, then host serial clock
    logic serial_in_pin;        // host to device data
    logic serial_out_pin;       // device to host data
    logic ready_handshake_pin;  // busy / monitor from device

    modport device (input boot_select_pin, input serial_clock_pin, input serial_in_pin,
                    output serial_out_pin, output ready_handshake_pin);
    modport host   (output boot_select_pin, output serial_clock_pin, output serial_in_pin,
                    input serial_out_pin, input ready_handshake_pin);
endinterface

// *** logic/sdb_host.sv ***
module sdb_host #(
    parameter logic SYNC_MODE = 1'b1,             // strap level on the clock pin
    parameter int   BIT_CYCLES = sdb_pkg::BIT_CYC // async bit time in cycles
) (
    input  wire logic       clock,
    input  wire logic       resetn,
    sdb_link_if.host        link,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output logic            in_ready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                 bsy;   // busy synchroniser, stages 1..3
        logic                       busy;  // accepted busy level
        sdb_pkg::sdb_hst_t          st;    // sequencer
        logic [sdb_pkg::CNT_W-1:0]  cnt;   // timing counter
        logic [3:0]                 bitn;  // bit index
        logic [9:0]                 sh;    // outgoing bits
        logic                       sck;   // serial clock pin
        logic                       sdo;   // serial data pin
        logic                       rdy;   // user ready
    } sdb_host_t;

    sdb_host_t r;       // registered state
    sdb_host_t next_r;  // next state

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.bsy = {r.bsy[1:0], link.ready_handshake_pin};
        // change accepted once stages two and three agree
        if (r.bsy[1] == r.bsy[2]) begin
            next_r.busy = r.bsy[2];
        end
        next_r.cnt = r.cnt + 1'b1;
        next_r.rdy = 1'b0;
        unique case (r.st)
            sdb_pkg::H_WAIT: begin
                // in sync mode, next byte only after busy has returned low; async mode never waits
                next_r.rdy = SYNC_MODE ? !r.busy : 1'b1;
                if (in_valid && r.rdy) begin
                    next_r.rdy  = 1'b0;
                    next_r.cnt  = '0;
                    next_r.bitn = '0;
                    if (SYNC_MODE) begin
                        next_r.sh = {2'b00, in_data};
                        next_r.st = sdb_pkg::H_LOW;
                    end else begin
                        // start, eight data lsb first, one stop, no parity
                        next_r.sh  = {1'b1, in_data, 1'b0};
                        next_r.st  = sdb_pkg::H_UART;
                    end
                end
            end
            sdb_pkg::H_LOW: begin
                // host makes the clock, data set while low
                next_r.sck = 1'b0;
                next_r.sdo = r.sh[0];
                if (r.cnt == sdb_pkg::CNT_W'(sdb_pkg::SCK_HALF_CYC - 1)) begin
                    next_r.cnt = '0;
                    next_r.sck = 1'b1;
                    next_r.st  = sdb_pkg::H_HIGH;
                end
            end
            sdb_pkg::H_HIGH: begin
                if (r.cnt == sdb_pkg::CNT_W'(sdb_pkg::SCK_HALF_CYC - 1)) begin
                    next_r.cnt  = '0;
                    next_r.sh   = r.sh >> 1;
                    next_r.bitn = r.bitn + 1'b1;
                    next_r.st   = (r.bitn == 4'h7) ? sdb_pkg::H_GUARD : sdb_pkg::H_LOW;
                end
            end
            sdb_pkg::H_GUARD: begin
                // let the busy level settle before looking again
                if (r.cnt == sdb_pkg::CNT_W'(sdb_pkg::GUARD_CYC - 1)) begin
                    next_r.st = sdb_pkg::H_WAIT;
                end
            end
            sdb_pkg::H_UART: begin
                next_r.sdo = r.sh[0];
                if (r.cnt == sdb_pkg::CNT_W'(BIT_CYCLES - 1)) begin
                    next_r.cnt  = '0;
                    next_r.sh   = r.sh >> 1;
                    next_r.bitn = r.bitn + 1'b1;
                    if (r.bitn == 4'h9) begin
                        next_r.st = sdb_pkg::H_WAIT;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r      <= '0;
            r.bsy  <= 3'h7;
            r.busy <= 1'b1;
            r.st   <= sdb_pkg::H_WAIT;
            r.sck  <= SYNC_MODE;   // strap level held, high after reset in sync mode, low in async mode
            r.sdo  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.boot_select_pin  = 1'b0;  // download always requested
    assign link.serial_clock_pin = r.sck;
    assign link.serial_in_pin    = r.sdo;
    assign in_ready              = r.rdy;
endmodule

// *** tb/sdb_props.sv ***
module sdb_props (
    input wire logic clock,
    input wire logic resetn,
    input wire logic boot_select_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic ready_handshake_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // serial clock edge tracking
    // ----------------------------------------
    logic [2:0] bit_cnt; // rising serial clock edges mod 8
    logic       sck_q;   // serial clock one cycle back
    logic       sck_rise;
    assign sck_rise = serial_clock_pin & ~sck_q;
    // count bit edges so byte starts are known
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 3'h0;
            sck_q   <= 1'b1;
        end else begin
            sck_q   <= serial_clock_pin;
            bit_cnt <= bit_cnt + {2'h0, sck_rise};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // link checks
    // ----------------------------------------
    boot_low_a: assert property (boot_select_pin == 1'b0)
        else $error("boot select not low");
    init_busy_a: assert property ($rose(resetn) |-> ready_handshake_pin [*8])
        else $error("handshake low during init");
    init_ready_a: assert property ($rose(resetn) |-> ##[20:40] !ready_handshake_pin)
        else $error("handshake not low after init");
    clk_high_a: assert property ($rose(resetn) |-> serial_clock_pin [*8])
        else $error("serial clock not high after reset");
    start_ready_a: assert property (sck_rise && bit_cnt == 3'h0 |-> !ready_handshake_pin)
        else $error("byte started while busy");
    busy_rise_a: assert property (sck_rise && bit_cnt == 3'h0 |-> ##[1:8] ready_handshake_pin)
        else $error("busy not raised after first bit");
    busy_hold_a: assert property (sck_rise && bit_cnt != 3'h0 |-> ready_handshake_pin)
        else $error("busy dropped inside a byte");
    data_stable_a: assert property ($changed(serial_in_pin) |-> !serial_clock_pin)
        else $error("data moved while clock high");
    out_idle_a: assert property (serial_out_pin == 1'b1)
        else $error("serial out left idle level");
endmodule

// *** tb/serial_program_download_boot_tb.sv ***
module serial_program_download_boot_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic        clock  = 1'b0;
    logic        resetn = 1'b0;
    logic        iv [2] = '{1'b0, 1'b0}; // host byte valid per pair
    logic [7:0]  id [2] = '{8'h00, 8'h00};
    logic        ir [2];
    logic [15:0] ra = 16'h0000;           // shared ram read address
    logic [7:0]  rdd [2];
    logic        run_o [2];
    logic        sm_o [2];
    logic        en_o [2];
    logic [15:0] pc [2];
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    logic [7:0]  dat [$];                 // program bytes of last frame
    sdb_link_if link_s ();                // sync pair
    sdb_link_if link_a ();                // async pair
    always #2 clock = ~clock;
    // sync pair keeps its defaults: strap high, bit time unused there
    sdb_host u_sdb_host (.clock(clock), .resetn(resetn), .link(link_s),
        .in_valid(iv[0]), .in_data(id[0]), .in_ready(ir[0]));
    sdb_device u_sdb_device (.clock(clock), .resetn(resetn), .link(link_s), .rd_addr(ra),
        .rd_data(rdd[0]), .run(run_o[0]), .run_addr(pc[0]), .sync_mode(sm_o[0]), .enabled(en_o[0]));
    sdb_host #(.SYNC_MODE(1'b0), .BIT_CYCLES(40)) u_sdb_host_a (.clock(clock), .resetn(resetn), .link(link_a),
        .in_valid(iv[1]), .in_data(id[1]), .in_ready(ir[1]));
    sdb_device #(.BIT_CYCLES(40)) u_sdb_device_a (.clock(clock), .resetn(resetn), .link(link_a), .rd_addr(ra),
        .rd_data(rdd[1]), .run(run_o[1]), .run_addr(pc[1]), .sync_mode(sm_o[1]), .enabled(en_o[1]));
    sdb_props u_sdb_props (.clock(clock), .resetn(resetn), .boot_select_pin(link_s.boot_select_pin),
        .serial_clock_pin(link_s.serial_clock_pin), .serial_in_pin(link_s.serial_in_pin),
        .serial_out_pin(link_s.serial_out_pin), .ready_handshake_pin(link_s.ready_handshake_pin));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // low byte of the program data sum
    function automatic logic [7:0] sum8();
        logic [7:0] s;
        s = 8'h00;
        foreach (dat[i]) s += dat[i];
        return s;
    endfunction
    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // hold valid until the host takes the byte
    task automatic send(input int p, input logic [7:0] b);
        @(negedge clock);
        iv[p] = 1'b1;
        id[p] = b;
        while (ir[p] !== 1'b1) @(negedge clock);
        @(negedge clock);
        iv[p] = 1'b0;
    endtask
    // whole frame, checksum spoilt by bad
    task automatic frame(input int p, input logic [15:0] n, input logic [7:0] bad);
        dat.delete();
        repeat (n) dat.push_back(8'($urandom));
        send(p, sdb_pkg::CMD_DOWNLOAD);
        send(p, n[7:0]);
        send(p, n[15:8]);
        send(p, sum8() ^ bad);
        foreach (dat[i]) send(p, dat[i]);
        repeat (2500) @(negedge clock);
    endtask
    task automatic rd(input int p, input int i, input logic [7:0] exp);
        ra = sdb_pkg::LOAD_BASE + 16'(i);
        repeat (3) @(negedge clock);
        chk({8'h00, rdd[p]}, {8'h00, exp});
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h3B4A0DB8));
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (40) @(negedge clock);
        chk(16'(en_o[0]), 16'h0001);
        chk(16'(sm_o[0]), 16'h0001);
        chk(16'(sm_o[1]), 16'h0000);
        chk(16'(link_a.ready_handshake_pin), 16'h0000);
        chk(16'(en_o[1]), 16'h0001);
        $display("test straps done");
        send(0, 8'h55); // stray byte before command
        frame(0, 16'(1 + $urandom % 8), 8'h01);
        chk(16'(run_o[0]), 16'h0000);
        rd(0, 0, 8'h00);
        chk(16'(link_s.ready_handshake_pin), 16'h0000);
        $display("test bad checksum done");
        frame(0, 16'(9 + $urandom % 8), 8'h00);
        chk(16'(run_o[0]), 16'h0001);
        chk(pc[0], sdb_pkg::EXEC_START);
        foreach (dat[i]) rd(0, i, dat[i]);
        $display("test sync download done");
        // empty program with a nonzero checksum must be refused
        frame(1, 16'h0000, 8'h01);
        chk(16'(run_o[1]), 16'h0000);
        $display("test empty frame done");
        frame(1, 16'(9 + $urandom % 8), 8'h00);
        chk(16'(run_o[1]), 16'h0001);
        chk(16'(link_a.ready_handshake_pin), 16'h0001);
        chk(pc[1], sdb_pkg::EXEC_START);
        chk(16'(link_a.serial_out_pin), 16'h0001);
        foreach (dat[i]) rd(1, i, dat[i]);
        rd(1, sdb_pkg::RAM_DEPTH, 8'h00);
        $display("test async download done");
        wrap_up();
    end
endmodule
